// [rtl/qps_pkg.sv]
// constants and types for the quad pot serial command header
//
// Function
// [R1] every frame opens with an addressing byte whose upper four bits carry the device-type field.
// [R2] the two low address bits are compared with the two strap inputs and the frame continues only on a match.
// [R3] with several devices on the bus only the one whose strap matches acts; the rest change nothing.
// [R4] the master sends the two bits between type field and address field as zero.
// [R5] the second byte is the instruction byte and its upper four bits are the opcode.
// [R6] the nonvolatile-register select field of the instruction byte picks one of four data registers.
// [R7] the two low bits of the instruction byte pick one of four wiper position registers.
// [R8] the master waits at least 1 ms after power-up before any read or write command.
// [R9] a data-register write is committed only when chip select rises after the complete sequence.
// [R10] read status returns the write-in-progress flag, which is 1 while a nonvolatile write runs.
// [R11] a nonvolatile change lasts at most 5 ms and the write-in-progress flag stays set meanwhile.
// [R12] on address mismatch or nonzero reserved bits the rest of the frame is ignored with the output released.
package qps_pkg;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int POWERUP_MS = 1;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int NS_PER_MS = 1000000;
	// least time rounds up, longest time rounds down
	localparam int POWERUP_CYCLES = (POWERUP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLES = (WRITE_CYCLE_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int TIMER_W = 20;

	// =====================================================================
	// frame layout
	localparam int BITS_ADDR = 8;
	localparam int BITS_INSTR = 16;
	localparam int BITS_DATA = 24;
	localparam int CNT_W = 5;
	localparam logic [1:0] RSVD_ZERO = 2'h0;

	// =====================================================================
	// opcodes that the header front end itself acts on, and the status byte pad
	localparam logic [3:0] OP_WR_DATA_REG = 4'hc;
	localparam logic [3:0] OP_XFR_WIPER_TO_DATA = 4'he;
	localparam logic [3:0] OP_GANG_WIPER_TO_DATA = 4'h8;
	localparam logic [3:0] OP_RD_STATUS = 4'h5;
	localparam logic [7:0] STATUS_PAD = 8'h00;

	typedef struct packed {
		logic [3:0] opcode;
		logic nv_reg_select_hi;
		logic nv_reg_select_lo;
		logic [1:0] wiper_sel;
	} qps_instr_t;

	typedef struct packed {
		logic [3:0] dev_type;
		logic [1:0] rsvd;
		logic slave_addr_strap_hi;
		logic slave_addr_strap_lo;
	} qps_addr_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INSTR = 3'b010,
		ST_DATA = 3'b011,
		ST_IGNORE = 3'b100
	} qps_state_t;

endpackage : qps_pkg

// [rtl/qps_header.sv]
// serial command header decoder of the quad pot, device side
`timescale 1ns/10ps
`default_nettype none
module qps_header #(
	parameter int POWERUP_CYCLES = qps_pkg::POWERUP_CYCLES,
	parameter int WRITE_CYCLES = qps_pkg::WRITE_CYCLES,
	// arbitrary neutral device-type value
	parameter logic [3:0] DEV_TYPE = 4'ha
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe_n,
	input wire logic slave_addr_strap_hi,
	input wire logic slave_addr_strap_lo,
	output logic recall_busy,
	output logic cmd_valid,
	output qps_pkg::qps_instr_t cmd,
	output logic data_valid,
	output logic [7:0] data_byte,
	output logic nv_commit,
	output logic frame_ignored,
	output logic write_in_progress_flag
);

	// =====================================================================
	// elaboration checks
	if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << qps_pkg::TIMER_W)) begin : g_chk_pu
		$error("POWERUP_CYCLES out of range");
	end
	if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << qps_pkg::TIMER_W)) begin : g_chk_wr
		$error("WRITE_CYCLES out of range");
	end

	// =====================================================================
	// pin synchronisers; the third stage only serves edge detection
	logic [2:0] sck_s;
	logic [2:0] cs_s;
	logic [1:0] si_s;
	logic [1:0] hi_s;
	logic [1:0] lo_s;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_s <= 3'h0;
			cs_s <= 3'h7;
			si_s <= 2'h0;
			hi_s <= 2'h0;
			lo_s <= 2'h0;
		end else begin
			sck_s <= {sck_s[1:0], spi_sck};
			cs_s <= {cs_s[1:0], spi_cs_n};
			si_s <= {si_s[0], spi_si};
			hi_s <= {hi_s[0], slave_addr_strap_hi};
			lo_s <= {lo_s[0], slave_addr_strap_lo};
		end
	end
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic [1:0] strap;
	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign sck_fall = ~sck_s[1] & sck_s[2];
	assign cs_fall = ~cs_s[1] & cs_s[2];
	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign strap = {hi_s[1], lo_s[1]};

	// =====================================================================
	// power-up recall and nonvolatile write timers
	logic [qps_pkg::TIMER_W-1:0] pu_cnt;
	logic [qps_pkg::TIMER_W-1:0] wr_cnt;
	logic [qps_pkg::TIMER_W-1:0] next_pu_cnt;
	logic [qps_pkg::TIMER_W-1:0] next_wr_cnt;
	always_comb begin
		next_pu_cnt = pu_cnt;
		next_wr_cnt = wr_cnt;
		if (pu_cnt != '0) begin
			next_pu_cnt = pu_cnt - 1'b1; // R8
		end
		if (nv_commit) begin
			next_wr_cnt = qps_pkg::TIMER_W'(WRITE_CYCLES); // R11
		end else if (wr_cnt != '0) begin
			next_wr_cnt = wr_cnt - 1'b1; // R11
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pu_cnt <= qps_pkg::TIMER_W'(POWERUP_CYCLES);
			wr_cnt <= '0;
		end else begin
			pu_cnt <= next_pu_cnt;
			wr_cnt <= next_wr_cnt;
		end
	end
	assign recall_busy = (pu_cnt != '0);
	assign write_in_progress_flag = (wr_cnt != '0); // R10

	// =====================================================================
	// frame engine
	qps_pkg::qps_state_t state;
	qps_pkg::qps_state_t next_state;
	logic [qps_pkg::CNT_W-1:0] bit_cnt;
	logic [qps_pkg::CNT_W-1:0] next_bit_cnt;
	logic [7:0] rx;
	logic [7:0] next_rx;
	logic [7:0] tx;
	logic [7:0] next_tx;
	qps_pkg::qps_addr_t addr_byte;
	qps_pkg::qps_addr_t next_addr_byte;
	qps_pkg::qps_instr_t next_cmd;
	logic next_cmd_valid;
	logic next_data_valid;
	logic [7:0] next_data_byte;
	logic next_nv_commit;
	logic next_frame_ignored;
	logic [7:0] shifted;
	logic is_status;
	logic ok_two_byte;

	assign shifted = {rx[6:0], si_s[1]};
	assign is_status = (cmd.opcode == qps_pkg::OP_RD_STATUS);
	// transfers into a data register end after the instruction byte
	assign ok_two_byte = (cmd.opcode == qps_pkg::OP_XFR_WIPER_TO_DATA) ||
		(cmd.opcode == qps_pkg::OP_GANG_WIPER_TO_DATA);

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_rx = rx;
		next_tx = tx;
		next_addr_byte = addr_byte;
		next_cmd = cmd;
		next_cmd_valid = 1'b0;
		next_data_valid = 1'b0;
		next_data_byte = data_byte;
		next_nv_commit = 1'b0;
		next_frame_ignored = 1'b0;
		if (cs_rise) begin
			next_state = qps_pkg::ST_IDLE;
			// a new write is refused while the previous one still runs
			if (state == qps_pkg::ST_DATA && !write_in_progress_flag) begin
				if ((cmd.opcode == qps_pkg::OP_WR_DATA_REG &&
					bit_cnt == qps_pkg::CNT_W'(qps_pkg::BITS_DATA)) ||
					(ok_two_byte && bit_cnt == qps_pkg::CNT_W'(qps_pkg::BITS_INSTR))) begin
					next_nv_commit = 1'b1; // R9
				end
			end
		end else if (cs_fall) begin
			next_bit_cnt = '0;
			next_state = recall_busy ? qps_pkg::ST_IGNORE : qps_pkg::ST_ADDR; // R8
		end else if (sck_rise && (state == qps_pkg::ST_ADDR || state == qps_pkg::ST_INSTR ||
			state == qps_pkg::ST_DATA)) begin
			next_rx = shifted;
			if (bit_cnt != '1) begin
				next_bit_cnt = bit_cnt + 1'b1;
			end
			case (next_bit_cnt)
				qps_pkg::CNT_W'(qps_pkg::BITS_ADDR): begin
					next_addr_byte = shifted;
					if (next_addr_byte.dev_type == DEV_TYPE && // R1
						next_addr_byte.rsvd == qps_pkg::RSVD_ZERO && // R12
						{next_addr_byte.slave_addr_strap_hi,
						next_addr_byte.slave_addr_strap_lo} == strap) begin // R2 R3
						next_state = qps_pkg::ST_INSTR;
					end else begin
						next_state = qps_pkg::ST_IGNORE; // R12
						next_frame_ignored = 1'b1;
					end
				end
				qps_pkg::CNT_W'(qps_pkg::BITS_INSTR): begin
					next_cmd = shifted; // R5 R6 R7
					next_cmd_valid = 1'b1;
					next_state = qps_pkg::ST_DATA;
					next_tx = (next_cmd.opcode == qps_pkg::OP_RD_STATUS) ?
						(qps_pkg::STATUS_PAD | {7'h0, write_in_progress_flag}) : tx; // R10
				end
				qps_pkg::CNT_W'(qps_pkg::BITS_DATA): begin
					next_data_byte = shifted;
					next_data_valid = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (sck_fall && state == qps_pkg::ST_DATA &&
			bit_cnt > qps_pkg::CNT_W'(qps_pkg::BITS_INSTR)) begin
			next_tx = {tx[6:0], 1'b0}; // R10
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= qps_pkg::ST_IDLE;
			bit_cnt <= '0;
			rx <= 8'h00;
			tx <= 8'h00;
			addr_byte <= '0;
			cmd <= '0;
			cmd_valid <= 1'b0;
			data_valid <= 1'b0;
			data_byte <= 8'h00;
			nv_commit <= 1'b0;
			frame_ignored <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			rx <= next_rx;
			tx <= next_tx;
			addr_byte <= next_addr_byte;
			cmd <= next_cmd;
			cmd_valid <= next_cmd_valid;
			data_valid <= next_data_valid;
			data_byte <= next_data_byte;
			nv_commit <= next_nv_commit;
			frame_ignored <= next_frame_ignored;
		end
	end

	// output driven only while a status byte is going out
	assign spi_so = tx[7];
	assign spi_so_oe_n = !(state == qps_pkg::ST_DATA && is_status &&
		bit_cnt < qps_pkg::CNT_W'(qps_pkg::BITS_DATA)); // R12

	// =====================================================================
	// checks
	logic [qps_pkg::TIMER_W-1:0] wip_len;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wip_len <= '0;
		end else begin
			wip_len <= write_in_progress_flag ? wip_len + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_type_match: assert property (cmd_valid |-> addr_byte.dev_type == DEV_TYPE) // R1
		else $error("command accepted with wrong device type");
	chk_addr_match: assert property (cmd_valid |-> // R2
		{addr_byte.slave_addr_strap_hi, addr_byte.slave_addr_strap_lo} == strap)
		else $error("command accepted with mismatched address");
	chk_mismatch_quiet: assert property (frame_ignored |-> ##1 !cmd_valid [*8]) // R3
		else $error("ignored frame produced a command");
	chk_opcode_field: assert property (cmd_valid |-> cmd.opcode == rx[7:4]) // R5
		else $error("opcode not taken from top of instruction byte");
	chk_nv_select: assert property (cmd_valid |-> // R6
		{cmd.nv_reg_select_hi, cmd.nv_reg_select_lo} == rx[3:2])
		else $error("data register select wrong");
	chk_wiper_select: assert property (cmd_valid |-> cmd.wiper_sel == rx[1:0]) // R7
		else $error("wiper select wrong");
	chk_recall_gate: assert property (recall_busy |-> !cmd_valid) // R8
		else $error("command accepted during power-up recall");
	chk_commit_on_cs: assert property (nv_commit |-> $past(cs_rise) && $past(state) == qps_pkg::ST_DATA) // R9
		else $error("commit without chip select rising");
	chk_status_load: assert property (cmd_valid && cmd.opcode == qps_pkg::OP_RD_STATUS |->
		tx == {7'h0, $past(write_in_progress_flag)}) // R10
		else $error("status byte does not carry write flag");
	chk_wip_hold: assert property (nv_commit |=> write_in_progress_flag) // R11
		else $error("write flag not set after commit");
	chk_wip_length: assert property ($fell(write_in_progress_flag) |->
		$past(wip_len) == qps_pkg::TIMER_W'(WRITE_CYCLES - 1)) // R11
		else $error("write flag length wrong");
	chk_ignore_release: assert property (state == qps_pkg::ST_IGNORE |-> spi_so_oe_n) // R12
		else $error("output driven in ignored frame");

	cov_command: cover property (cmd_valid);
	cov_ignored: cover property (frame_ignored);
	cov_commit: cover property (nv_commit);
	cov_status: cover property (!spi_so_oe_n ##1 spi_so_oe_n);

endmodule : qps_header
`default_nettype wire

// [dv/qps_spi_master.sv]
// spi master model standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module qps_spi_master (
	input wire logic core_clk,
	input wire logic spi_so,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si
);
	// =====================================================================
	// half of the 80 ns link period, in core cycles
	localparam int HALF = 4;
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	task automatic half_wait();
		repeat (HALF) @(posedge core_clk);
	endtask : half_wait
	// address byte, instruction byte, then data byte, msb first
	task automatic xfer(input int nbits, input logic [23:0] frame, output logic [7:0] rx);
		rx = 8'h00;
		spi_cs_n <= 1'b0;
		half_wait();
		for (int i = 0; i < nbits; i++) begin
			spi_si <= frame[23 - i];
			half_wait();
			spi_sck <= 1'b1;
			rx = {rx[6:0], spi_so};
			half_wait();
			spi_sck <= 1'b0;
		end
		half_wait();
		spi_cs_n <= 1'b1;
		// data line shows no stale level between frames
		spi_si <= ~spi_si;
		half_wait();
	endtask : xfer
endmodule : qps_spi_master
`default_nettype wire

// [dv/tb.sv]
// self-checking bench of the quad pot serial command header
`timescale 1ns/10ps
`default_nettype none
module tb;
	// short counts keep the run brief
	localparam int PUC = 20;
	localparam int WRC = 400;
	localparam logic [1:0] STRAP = 2'h2;
	localparam logic [7:0] ADR = {4'ha, 2'h0, STRAP};
	logic core_clk, arst_n, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
	logic recall_busy, cmd_valid, data_valid, nv_commit, frame_ignored, write_in_progress_flag;
	qps_pkg::qps_instr_t cmd;
	logic [7:0] data_byte, rx;
	logic [1:0] strap;
	logic so_line;
	int error_cnt = 0, n_tests = 0, n_cmd = 0, n_dat = 0, n_com = 0, n_ign = 0, n_oe = 0;
	int wip_len = 0, b_cmd, b_dat, b_com, b_ign, b_oe;

	qps_header #(.POWERUP_CYCLES(PUC), .WRITE_CYCLES(WRC), .DEV_TYPE(4'ha)) uut (
		.core_clk(core_clk), .arst_n(arst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
		.slave_addr_strap_hi(strap[1]), .slave_addr_strap_lo(strap[0]),
		.recall_busy(recall_busy), .cmd_valid(cmd_valid), .cmd(cmd),
		.data_valid(data_valid), .data_byte(data_byte), .nv_commit(nv_commit),
		.frame_ignored(frame_ignored), .write_in_progress_flag(write_in_progress_flag));
	// a released output line floats high on its pull-up
	assign so_line = spi_so_oe_n ? 1'b1 : spi_so;
	qps_spi_master m (.core_clk(core_clk), .spi_so(so_line), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si));

	// =====================================================================
	// clock, pulse counters
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (cmd_valid === 1'b1) n_cmd++;
		if (data_valid === 1'b1) n_dat++;
		if (nv_commit === 1'b1) n_com++;
		if (frame_ignored === 1'b1) n_ign++;
		if (spi_so_oe_n === 1'b0) n_oe++;
		if (write_in_progress_flag === 1'b1) wip_len++;
	end

	// =====================================================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check
	task automatic frame(input int n, input logic [23:0] f);
		{b_cmd, b_dat, b_com, b_ign, b_oe} = {n_cmd, n_dat, n_com, n_ign, n_oe};
		m.xfer(n, f, rx);
		repeat (3) @(posedge core_clk);
	endtask : frame
	task automatic wait_idle();
		for (int k = 0; k < WRC + 10 && write_in_progress_flag !== 1'b0; k++) @(posedge core_clk);
		check(write_in_progress_flag, 1'b0, "flag stuck");
	endtask : wait_idle

	// =====================================================================
	// scenarios
	task automatic t_reset();
		int c;
		c = 0;
		check({recall_busy, spi_so_oe_n, write_in_progress_flag, nv_commit}, 4'hc, "reset");
		@(posedge core_clk);
		arst_n <= 1'b1;
		// no frame before recall ends
		while (recall_busy === 1'b1 && c < 100) begin
			@(posedge core_clk);
			c++;
		end
		check(c >= PUC && c <= PUC + 2, 1, "recall time");
		$display("done t_reset");
	endtask : t_reset
	task automatic t_write_status();
		wip_len = 0;
		frame(24, {ADR, 8'hc6, 8'h3c});
		check(n_cmd - b_cmd, 1, "cmd pulse");
		check(cmd, 8'hc6, "cmd fields");
		check(n_dat - b_dat, 1, "data pulse");
		check(data_byte, 8'h3c, "data");
		check(n_com - b_com, 1, "commit");
		frame(24, {ADR, 8'h50, 8'h00});
		check(rx, 8'h01, "status busy");
		check(n_oe > b_oe, 1, "so driven");
		wait_idle();
		check(wip_len, WRC, "flag length");
		frame(24, {ADR, 8'h50, 8'h00});
		check(rx, 8'h00, "status idle");
		$display("done t_write_status");
	endtask : t_write_status
	task automatic t_ignore();
		logic [7:0] bad [3];
		bad = '{ADR ^ 8'h01, ADR | 8'h08, ADR ^ 8'hf0};
		for (int i = 0; i < 3; i++) begin
			frame(24, {bad[i], 8'h50, 8'h00});
			check(n_ign - b_ign, 1, "ignored");
			check(n_cmd - b_cmd, 0, "acted");
			check(n_oe - b_oe, 0, "so driven");
			check(rx, 8'hff, "so released");
		end
		// another strap setting moves the device to a new address
		strap <= 2'h1;
		repeat (3) @(posedge core_clk);
		frame(24, {ADR, 8'h50, 8'h00});
		check(n_ign - b_ign, 1, "old address");
		frame(24, {ADR ^ 8'h03, 8'h50, 8'h00});
		check(n_cmd - b_cmd, 1, "new address");
		check(rx, 8'h00, "new address status");
		strap <= STRAP;
		repeat (3) @(posedge core_clk);
		$display("done t_ignore");
	endtask : t_ignore
	task automatic t_ops();
		logic [3:0] ops [2];
		ops = '{4'he, 4'h8};
		for (int i = 0; i < 2; i++) begin
			// a commit is refused while the previous write still runs
			wait_idle();
			frame(16, {ADR, ops[i], 4'h9, 8'h00});
			check(cmd, {ops[i], 4'h9}, "op fields");
			check(n_com - b_com, 1, "op commit");
		end
		frame(16, {ADR, 8'he9, 8'h00});
		check(n_com - b_com, 0, "busy commit");
		wait_idle();
		frame(20, {ADR, 8'hc1, 8'ha5});
		check(n_com - b_com, 0, "short write");
		$display("done t_ops");
	endtask : t_ops
	task automatic t_recall_gate();
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		check({recall_busy, spi_so_oe_n, write_in_progress_flag, cmd_valid, cmd}, 12'hc00,
			"mid reset");
		arst_n <= 1'b1;
		// a frame that starts inside recall is dropped whole
		frame(16, {ADR, 8'he9, 8'h00});
		check(n_cmd - b_cmd, 0, "cmd in recall");
		check(n_com - b_com, 0, "commit in recall");
		check(recall_busy, 1'b0, "recall over");
		frame(16, {ADR, 8'he9, 8'h00});
		check(n_com - b_com, 1, "commit after recall");
		$display("done t_recall_gate");
	endtask : t_recall_gate

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial begin
		arst_n = 1'b0;
		strap = STRAP;
		repeat (20) @(posedge core_clk);
		t_reset();
		t_write_status();
		t_ignore();
		t_ops();
		t_recall_gate();
		end_of_test();
	end
	initial begin
		#200us;
		error_cnt++;
		$display("ERROR %0t watchdog", $time);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
